// ### include/hia_pkg.sv
// Package with register map, field layout, carrier types and state of the host interrupt aggregator.
package hia_pkg;

  localparam int HIA_ADDR_W = 12;
  localparam int HIA_NQ     = 8;
  localparam int HIA_QW     = 4;

  // Register byte offsets.
  localparam logic [11:0] OFS_RX_DELAY    = 12'h180;
  localparam logic [11:0] OFS_WATERMARK   = 12'h190;
  localparam logic [11:0] OFS_POWER       = 12'h19C;
  localparam logic [11:0] OFS_QS_EVENTS   = 12'h1C0;
  localparam logic [11:0] OFS_QS_MASK     = 12'h1C4;
  localparam logic [11:0] OFS_OU_EVENTS   = 12'h1C8;
  localparam logic [11:0] OFS_OU_MASK     = 12'h1CC;
  localparam logic [11:0] OFS_TR_EVENTS   = 12'h1D0;
  localparam logic [11:0] OFS_TR_MASK     = 12'h1D4;
  localparam logic [11:0] OFS_RR_EVENTS   = 12'h1D8;
  localparam logic [11:0] OFS_RR_MASK     = 12'h1DC;
  localparam logic [11:0] OFS_TOP_STATUS  = 12'h1E8;
  localparam logic [11:0] OFS_TOP_MASK    = 12'h1EC;

  // Field positions.
  localparam int QS_DONE_RISE = 3;
  localparam int QS_DONE_FALL = 2;
  localparam int QS_A_RISE    = 1;
  localparam int QS_B_RISE    = 0;
  localparam int OU_OVERFLOW  = 3;
  localparam int OU_UNDERRUN  = 2;
  localparam int WM_THR_LSB   = 16;
  localparam int WM_THR_W     = 7;
  localparam int WM_FREE_LSB  = 24;
  localparam int RX_DELAY_W   = 24;
  localparam int PWR_EVENT    = 15;
  localparam int TOP_WAKE     = 20;
  localparam int TOP_QS       = 19;
  localparam int TOP_OU       = 18;
  localparam int TOP_PHY      = 17;
  localparam int TOP_ROLL     = 16;
  localparam int TOP_TX_BAD   = 12;
  localparam int TOP_RX_BAD   = 11;
  localparam int TOP_RX_LATE  = 8;
  localparam int TOP_RX_EARLY = 7;
  localparam int TOP_TX_LATE  = 5;
  localparam int TOP_TX_EARLY = 4;
  localparam int TOP_WMARK    = 3;
  localparam int TOP_NOBLOCK  = 2;
  localparam int TOP_PAUSE    = 1;
  localparam int TOP_CLASS    = 0;

  localparam logic [31:0] OU_VALID_BITS = 32'hCCCC_CCCC;
  localparam logic [15:0] TOP_LOW_BITS  = 16'h19BF;
  localparam logic [31:0] REG_RESET     = 32'h0000_0000;

  typedef enum logic [1:0] {
    HIA_RX_IDLE = 2'b01,
    HIA_RX_WAIT = 2'b10
  } hia_rx_state_t;

  // Event sources from the MAC, all on the bus clock.
  typedef struct packed {
    logic [7:0]  done_flag;    // Queue completion flag levels.
    logic [7:0]  flag_a;       // Queue flag A levels.
    logic [7:0]  flag_b;       // Queue flag B levels.
    logic [7:0]  overflow;     // Queue overflow pulses.
    logic [7:0]  underrun;     // Queue underrun pulses.
    logic [31:0] tx_rollover;  // Transmit counter wrap pulses.
    logic [31:0] rx_rollover;  // Receive counter wrap pulses.
    logic        phy_irq;      // PHY interrupt level.
    logic        tx_bad;
    logic        rx_bad;
    logic        rx_frame_done;
    logic        rx_start;
    logic        byte_tick;    // One pulse per received byte time.
    logic        tx_start;
    logic        tx_done;
    logic        tx_notify_early; // Per-packet request, valid with tx_start.
    logic        tx_notify_late;  // Per-packet request, valid with tx_done.
    logic [6:0]  free_blocks;
    logic        no_block;
    logic        pause_active;
    logic        class_irq;
    logic        wake;
  } hia_events_t;

  typedef struct packed {
    logic [31:0]     qs_ev;
    logic [31:0]     qs_mask;
    logic [31:0]     ou_ev;
    logic [31:0]     ou_mask;
    logic [31:0]     tr_ev;
    logic [31:0]     tr_mask;
    logic [31:0]     rr_ev;
    logic [31:0]     rr_mask;
    logic [15:0]     top_low;
    logic [31:0]     top_mask;
    logic [23:0]     rx_delay_cfg;
    logic [6:0]      wm_thr;
    logic            pwr_event;
    logic [7:0]      prev_done;
    logic [7:0]      prev_a;
    logic [7:0]      prev_b;
    logic            prev_pause;
    logic            below_wm;
    logic [23:0]     rx_cnt;
    hia_rx_state_t   rx_state;
    logic [31:0]     rdata;
    logic            irq;
  } hia_state_t;

endpackage

// ### testbench/hia_aggregator_tb.sv
// Self-checking bench of the host interrupt aggregator with a reference model.
`timescale 1ns/100ps
module hia_aggregator_tb;
  import hia_pkg::*;
  localparam logic [11:0] EV_A [4]  = '{OFS_QS_EVENTS, OFS_OU_EVENTS, OFS_TR_EVENTS, OFS_RR_EVENTS};
  localparam logic [11:0] MK_A [4]  = '{OFS_QS_MASK, OFS_OU_MASK, OFS_TR_MASK, OFS_RR_MASK};
  localparam int          TOPB [4]  = '{TOP_QS, TOP_OU, TOP_ROLL, TOP_ROLL};
  localparam logic [11:0] ALL  [14] = '{OFS_RX_DELAY, OFS_WATERMARK, OFS_POWER, OFS_QS_EVENTS, OFS_QS_MASK,
    OFS_OU_EVENTS, OFS_OU_MASK, OFS_TR_EVENTS, OFS_TR_MASK, OFS_RR_EVENTS, OFS_RR_MASK, OFS_TOP_STATUS,
    OFS_TOP_MASK, 12'h1E4};
  logic        i_ref_clk, i_rst, i_wr, i_rd, o_int, o_power_event_n;
  logic [11:0] i_addr;
  logic [31:0] i_wdata, o_rdata, rv;
  hia_events_t i_ev, base, e;
  bit   [31:0] x [4];
  bit   [31:0] m [4];
  bit   [31:0] t;
  bit   [15:0] lfsr_q;
  logic [31:0] exp_q [$];
  int          mismatches = 0;
  int          num_checks = 0;
  int          cycles = 0;

  hia_aggregator i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_ev(i_ev), .o_rdata(o_rdata), .o_int(o_int), .o_power_event_n(o_power_event_n));
  hia_host_model i_host (.i_ref_clk(i_ref_clk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd));

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  function automatic bit [31:0] rnd();
    bit [31:0] r;
    for (int i = 0; i < 32; i++) begin
      lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      r = {r[30:0], lfsr_q[0]};
    end
    return r;
  endfunction

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: pin %b, expected %b", $time, got, exp);
    end
  endtask

  // Expected words queue in issue order and leave in the order that the port answers.
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    i_host.rd(a, rv);
    chk(rv, exp_q.pop_front());
  endtask

  // Events last one cycle; afterwards the inputs fall back to the held levels in base.
  task automatic pulse(input hia_events_t ev);
    @(posedge i_ref_clk);
    i_ev <= ev;
    @(posedge i_ref_clk);
    i_ev <= base;
  endtask

  task automatic apply();
    @(posedge i_ref_clk);
    i_ev <= base;
  endtask

  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    i_rst = 1'b1;
    i_ev = '0;
    base = '0;
    lfsr_q = 16'hD04F;
    repeat (6) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    foreach (ALL[k]) rdchk(ALL[k], 32'h0000_0000);
    chk_pin(o_power_event_n, 1'b1);
    for (int it = 0; it < 4; it++) begin
      i_host.wr(OFS_TOP_MASK, 32'h000D_0000);
      t = '0;
      for (int k = 0; k < 4; k++) begin
        m[k] = (it == 3) ? '0 : rnd();
        i_host.wr(MK_A[k], m[k]);
        rdchk(MK_A[k], m[k]);
      end
      e = base;
      e.done_flag = 8'(rnd());
      e.flag_a = 8'(rnd());
      e.flag_b = 8'(rnd());
      e.overflow = 8'(rnd());
      e.underrun = 8'(rnd());
      e.tx_rollover = rnd();
      e.rx_rollover = rnd();
      for (int q = 0; q < 8; q++) begin
        x[0][4*q+:4] = {e.done_flag[q], e.done_flag[q], e.flag_a[q], e.flag_b[q]};
        x[1][4*q+:4] = {e.overflow[q], e.underrun[q], 2'b00};
      end
      x[2] = e.tx_rollover;
      x[3] = e.rx_rollover;
      for (int k = 0; k < 4; k++) if ((x[k] & m[k]) != 0) t[TOPB[k]] = 1'b1;
      pulse(e);
      rdchk(OFS_TOP_STATUS, t);
      chk_pin(o_int, t != 0);
      for (int k = 0; k < 4; k++) rdchk(EV_A[k], x[k]);
      for (int k = 0; k < 4; k++) rdchk(EV_A[k], 32'h0000_0000);
      rdchk(OFS_TOP_STATUS, 32'h0000_0000);
    end
    base.phy_irq = 1'b1;
    base.pause_active = 1'b1;
    e = base;
    {e.tx_bad, e.rx_bad, e.rx_frame_done, e.no_block, e.class_irq, e.tx_start, e.tx_done} = 7'h7F;
    pulse(e);
    @(posedge i_ref_clk);
    #1;
    chk_pin(o_int, 1'b0);
    i_host.wr(OFS_TOP_MASK, 32'h0000_1000);
    @(posedge i_ref_clk);
    #1;
    chk_pin(o_int, 1'b1);
    rdchk(OFS_TOP_STATUS, 32'h0002_1907);
    rdchk(OFS_TOP_STATUS, 32'h0002_0000);
    chk_pin(o_int, 1'b0);
    e = base;
    {e.tx_start, e.tx_notify_early, e.tx_done, e.tx_notify_late} = 4'hF;
    pulse(e);
    base.phy_irq = 1'b0;
    apply();
    rdchk(OFS_TOP_STATUS, 32'h0000_0030);
    i_host.wr(OFS_RX_DELAY, 32'hFFFF_FFFF);
    rdchk(OFS_RX_DELAY, 32'h00FF_FFFF);
    i_host.wr(OFS_RX_DELAY, 32'h0000_0003);
    e = base;
    e.rx_start = 1'b1;
    pulse(e);
    e = base;
    e.byte_tick = 1'b1;
    pulse(e);
    pulse(e);
    rdchk(OFS_TOP_STATUS, 32'h0000_0000);
    pulse(e);
    rdchk(OFS_TOP_STATUS, 32'h0000_0080);
    base.free_blocks = 7'd10;
    apply();
    i_host.wr(OFS_WATERMARK, 32'h0005_0000);
    rdchk(OFS_WATERMARK, 32'h0A05_0000);
    base.free_blocks = 7'd6;
    apply();
    rdchk(OFS_TOP_STATUS, 32'h0000_0000);
    base.free_blocks = 7'd5;
    apply();
    rdchk(OFS_TOP_STATUS, 32'h0000_0008);
    e = base;
    e.wake = 1'b1;
    pulse(e);
    @(posedge i_ref_clk);
    #1;
    chk_pin(o_power_event_n, 1'b0);
    rdchk(OFS_TOP_STATUS, 32'h0010_0000);
    rdchk(OFS_POWER, 32'h0000_8000);
    i_host.clear_wake();
    rdchk(OFS_TOP_STATUS, 32'h0000_0000);
    chk_pin(o_power_event_n, 1'b1);
    e = base;
    e.tx_bad = 1'b1;
    fork
      pulse(e);
      rdchk(OFS_TOP_STATUS, 32'h0000_0000);
    join
    rdchk(OFS_TOP_STATUS, 32'h0000_1000);
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rdchk(OFS_TOP_MASK, 32'h0000_0000);
    rdchk(OFS_TOP_STATUS, 32'h0000_0002);
    summarize();
  end
endmodule // hia_aggregator_tb

// ### testbench/hia_host_model.sv
// Host processor model: master of the register port.
`timescale 1ns/100ps
module hia_host_model
  import hia_pkg::*;
(
  input  wire logic                  i_ref_clk, // Bus clock.
  input  wire logic [31:0]           i_rdata,   // Read data from the block.
  output logic      [HIA_ADDR_W-1:0] o_addr,    // Register byte address.
  output logic      [31:0]           o_wdata,   // Write data.
  output logic                       o_wr,      // Write strobe.
  output logic                       o_rd       // Read strobe.
);
  initial begin
    o_addr  = '0;
    o_wdata = '0;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // Released lines show the inverse of their last value, so a block that samples them late cannot pass by luck.
  task automatic wr(input logic [HIA_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    o_wr    <= 1'b1;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_ref_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask

  task automatic rd(input logic [HIA_ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    o_rd   <= 1'b1;
    o_addr <= a;
    @(posedge i_ref_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask

  // The wake summary stays up until the host writes one to the power event bit.
  task automatic clear_wake();
    wr(OFS_POWER, 32'h0000_8000);
  endtask
endmodule // hia_host_model

// ### verilog/hia_aggregator.sv
// Two-level host interrupt aggregator with register port and interrupt pin.
// Functional notes
// (RULE1) Queue status: four edge bits per queue.
// (RULE2) Second-level event bits latch, clear on read.
// (RULE3) Queue status mask gates summary only.
// (RULE4) Overflow/underrun bits at 4n+3, 4n+2 only.
// (RULE5) Overflow/underrun mask gates summary only.
// (RULE6) Transmit counter k wrap sets bit k.
// (RULE7) Receive counter k+32 wrap sets bit k.
// (RULE8) Rollover masks gate summary only.
// (RULE9) Top bits 20..16 are live summaries.
// (RULE10) Top low half clears on read.
// (RULE11) Bits 12, 11 flag transmit/receive errors.
// (RULE12) Bit 8 on each complete received frame.
// (RULE13) Bit 7 on receive start, delayed.
// (RULE14) Bits 4, 5 on requested transmit start/end.
// (RULE15) Bit 3 when free blocks reach threshold.
// (RULE16) Bit 2 when block request finds none.
// (RULE17) Bit 1 on pause change, bit 0 class.
// (RULE18) Top mask gates the interrupt pin.
// (RULE19) Receive delay is 24-bit byte count.
// (RULE20) 7-bit watermark threshold, zero disables.
// (RULE21) Power event set by wake, write-one clears.
// (RULE22) Summaries are OR of masked events.
// (RULE23) Event beats a same-cycle clearing read.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
module hia_aggregator
  import hia_pkg::*;
(
  input  wire logic                  i_ref_clk,      // Bus clock, 100 MHz.
  input  wire logic                  i_rst,          // Synchronous reset, active high.
  input  wire logic [HIA_ADDR_W-1:0] i_addr,         // Register byte address.
  input  wire logic [31:0]           i_wdata,        // Write data.
  input  wire logic                  i_wr,           // Write strobe.
  input  wire logic                  i_rd,           // Read strobe.
  input  wire hia_events_t           i_ev,           // Event sources.
  output logic [31:0]                o_rdata,        // Read data, cycle after strobe.
  output logic                       o_int,          // Host interrupt, active high level.
  output logic                       o_power_event_n // Power event output, active low.
);

  hia_state_t      st;
  hia_state_t      next_st;
  logic [31:0]     qs_set;
  logic [31:0]     ou_set;
  logic [31:0]     top_view;
  logic [15:0]     low_set;
  logic            rx_fire;
  logic            wm_below;
  logic            sum_qs;
  logic            sum_ou;
  logic            sum_roll;
  logic [31:0]     rd_value;

  // Per-queue edge and error mapping into the two nibble-packed registers.
  for (genvar q = 0; q < HIA_NQ; q++) begin : g_queue
    assign qs_set[q*HIA_QW+QS_DONE_RISE] = i_ev.done_flag[q] & ~st.prev_done[q]; // RULE1
    assign qs_set[q*HIA_QW+QS_DONE_FALL] = ~i_ev.done_flag[q] & st.prev_done[q]; // RULE1
    assign qs_set[q*HIA_QW+QS_A_RISE]    = i_ev.flag_a[q] & ~st.prev_a[q]; // RULE1
    assign qs_set[q*HIA_QW+QS_B_RISE]    = i_ev.flag_b[q] & ~st.prev_b[q]; // RULE1
    assign ou_set[q*HIA_QW+OU_OVERFLOW]  = i_ev.overflow[q]; // RULE4
    assign ou_set[q*HIA_QW+OU_UNDERRUN]  = i_ev.underrun[q]; // RULE4
    assign ou_set[q*HIA_QW+1]            = 1'b0;
    assign ou_set[q*HIA_QW]              = 1'b0;
  end

  assign sum_qs   = |(st.qs_ev & st.qs_mask); // RULE3 RULE22
  assign sum_ou   = |(st.ou_ev & st.ou_mask); // RULE5 RULE22
  assign sum_roll = |(st.tr_ev & st.tr_mask) | |(st.rr_ev & st.rr_mask); // RULE8 RULE22

  // Upper half has no storage of its own; it follows its sources.
  always_comb begin
    top_view               = REG_RESET;
    top_view[15:0]         = st.top_low & TOP_LOW_BITS;
    top_view[TOP_WAKE]     = st.pwr_event; // RULE9 RULE10
    top_view[TOP_QS]       = sum_qs; // RULE9
    top_view[TOP_OU]       = sum_ou; // RULE9
    top_view[TOP_PHY]      = i_ev.phy_irq; // RULE9
    top_view[TOP_ROLL]     = sum_roll; // RULE9
  end

  // A zero threshold disables the watermark; a fall is a move into the below state.
  assign wm_below = (st.wm_thr != '0) && (i_ev.free_blocks <= st.wm_thr); // RULE15 RULE20

  // A start with zero delay fires at once, also when it cuts a running wait short.
  assign rx_fire = (i_ev.rx_start && (st.rx_delay_cfg == '0))
                || ((st.rx_state == HIA_RX_WAIT) && !i_ev.rx_start && i_ev.byte_tick
                    && (st.rx_cnt == 24'h00_0001)); // RULE13 RULE19

  always_comb begin
    low_set               = '0;
    low_set[TOP_TX_BAD]   = i_ev.tx_bad; // RULE11
    low_set[TOP_RX_BAD]   = i_ev.rx_bad; // RULE11
    low_set[TOP_RX_LATE]  = i_ev.rx_frame_done; // RULE12
    low_set[TOP_RX_EARLY] = rx_fire; // RULE13
    low_set[TOP_TX_LATE]  = i_ev.tx_done & i_ev.tx_notify_late; // RULE14
    low_set[TOP_TX_EARLY] = i_ev.tx_start & i_ev.tx_notify_early; // RULE14
    low_set[TOP_WMARK]    = wm_below & ~st.below_wm; // RULE15
    low_set[TOP_NOBLOCK]  = i_ev.no_block; // RULE16
    low_set[TOP_PAUSE]    = i_ev.pause_active ^ st.prev_pause; // RULE17
    low_set[TOP_CLASS]    = i_ev.class_irq; // RULE17
  end

  always_comb begin
    case (i_addr)
      OFS_RX_DELAY:   rd_value = {8'h00, st.rx_delay_cfg};
      OFS_WATERMARK:  rd_value = {1'b0, i_ev.free_blocks, 1'b0, st.wm_thr, 16'h0000};
      OFS_POWER:      rd_value = {16'h0000, st.pwr_event, 15'h0000};
      OFS_QS_EVENTS:  rd_value = st.qs_ev;
      OFS_QS_MASK:    rd_value = st.qs_mask;
      OFS_OU_EVENTS:  rd_value = st.ou_ev & OU_VALID_BITS; // RULE4
      OFS_OU_MASK:    rd_value = st.ou_mask;
      OFS_TR_EVENTS:  rd_value = st.tr_ev;
      OFS_TR_MASK:    rd_value = st.tr_mask;
      OFS_RR_EVENTS:  rd_value = st.rr_ev;
      OFS_RR_MASK:    rd_value = st.rr_mask;
      OFS_TOP_STATUS: rd_value = top_view;
      OFS_TOP_MASK:   rd_value = st.top_mask;
      default:        rd_value = REG_RESET;
    endcase
  end

  always_comb begin
    next_st            = st;
    next_st.prev_done  = i_ev.done_flag;
    next_st.prev_a     = i_ev.flag_a;
    next_st.prev_b     = i_ev.flag_b;
    next_st.prev_pause = i_ev.pause_active;
    next_st.below_wm   = wm_below;
    next_st.rdata      = i_rd ? rd_value : REG_RESET;

    // Clearing read first, then new events OR in so a same-cycle event survives.
    if (i_rd) begin
      case (i_addr)
        OFS_QS_EVENTS:  next_st.qs_ev   = '0; // RULE2
        OFS_OU_EVENTS:  next_st.ou_ev   = '0; // RULE2
        OFS_TR_EVENTS:  next_st.tr_ev   = '0; // RULE2
        OFS_RR_EVENTS:  next_st.rr_ev   = '0; // RULE2
        OFS_TOP_STATUS: next_st.top_low = '0; // RULE10
        default:        next_st.top_low = st.top_low;
      endcase
    end
    next_st.qs_ev   = next_st.qs_ev | qs_set; // RULE2 RULE23
    next_st.ou_ev   = (next_st.ou_ev | ou_set) & OU_VALID_BITS; // RULE4 RULE23
    next_st.tr_ev   = next_st.tr_ev | i_ev.tx_rollover; // RULE6 RULE23
    next_st.rr_ev   = next_st.rr_ev | i_ev.rx_rollover; // RULE7 RULE23
    next_st.top_low = (next_st.top_low | low_set) & TOP_LOW_BITS; // RULE23

    if (i_wr) begin
      case (i_addr)
        OFS_RX_DELAY:  next_st.rx_delay_cfg = i_wdata[RX_DELAY_W-1:0]; // RULE19
        OFS_WATERMARK: next_st.wm_thr       = i_wdata[WM_THR_LSB +: WM_THR_W]; // RULE20
        OFS_POWER:     next_st.pwr_event    = st.pwr_event & ~i_wdata[PWR_EVENT]; // RULE21
        OFS_QS_MASK:   next_st.qs_mask      = i_wdata;
        OFS_OU_MASK:   next_st.ou_mask      = i_wdata;
        OFS_TR_MASK:   next_st.tr_mask      = i_wdata;
        OFS_RR_MASK:   next_st.rr_mask      = i_wdata;
        OFS_TOP_MASK:  next_st.top_mask     = i_wdata;
        default:       next_st.wm_thr       = st.wm_thr;
      endcase
    end
    // Wake wins over a write-one-to-clear in the same cycle.
    if (i_ev.wake) begin
      next_st.pwr_event = 1'b1; // RULE21 RULE23
    end

    // A new receive start always restarts the delay.
    case (st.rx_state)
      HIA_RX_IDLE: begin
        if (i_ev.rx_start && (st.rx_delay_cfg != '0)) begin
          next_st.rx_state = HIA_RX_WAIT; // RULE13
          next_st.rx_cnt   = st.rx_delay_cfg;
        end
      end
      HIA_RX_WAIT: begin
        if (i_ev.rx_start) begin
          next_st.rx_cnt = st.rx_delay_cfg;
          if (st.rx_delay_cfg == '0) begin
            next_st.rx_state = HIA_RX_IDLE;
          end
        end else if (i_ev.byte_tick) begin
          next_st.rx_cnt = st.rx_cnt - 24'h00_0001; // RULE19
          if (st.rx_cnt == 24'h00_0001) begin
            next_st.rx_state = HIA_RX_IDLE;
          end
        end
      end
      default: begin
        next_st.rx_state = HIA_RX_IDLE;
        next_st.rx_cnt   = '0;
      end
    endcase

    next_st.irq = |(top_view & st.top_mask); // RULE18 RULE22
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st          <= '0;
      st.rx_state <= HIA_RX_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata         = st.rdata;
  assign o_int           = st.irq;
  assign o_power_event_n = ~st.pwr_event; // RULE21

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_rx_last_tick;
    st.rx_state == HIA_RX_WAIT && st.rx_cnt == 24'h00_0001 && i_ev.byte_tick && !i_ev.rx_start;
  endsequence

  sequence s_rx_arm;
    st.rx_state == HIA_RX_IDLE && i_ev.rx_start && st.rx_delay_cfg > 24'h00_0001;
  endsequence

  a_qs_edge_latch: assert property ( // RULE1
    !i_ev.done_flag[0] ##1 i_ev.done_flag[0] |=> st.qs_ev[QS_DONE_RISE])
    else $error("Queue 0 completion rise not latched.");

  a_event_survives_read: assert property ( // RULE23
    i_rd && i_addr == OFS_TR_EVENTS && i_ev.tx_rollover[0] |=> st.tr_ev[0])
    else $error("Rollover event lost in clearing read.");

  a_clear_on_read: assert property ( // RULE2
    i_rd && i_addr == OFS_RR_EVENTS && i_ev.rx_rollover == '0 |=> st.rr_ev == '0)
    else $error("Receive rollover register not cleared by read.");

  a_top_low_clear: assert property ( // RULE10
    i_rd && i_addr == OFS_TOP_STATUS && low_set == '0 && !i_ev.wake |=> st.top_low == '0 && $stable(st.pwr_event))
    else $error("Top status read did not clear only the low half.");

  a_rx_early_delay: assert property ( // RULE13
    s_rx_last_tick |=> st.top_low[TOP_RX_EARLY])
    else $error("Early receive bit not set after delay.");

  a_rx_arm_wait: assert property ( // RULE19
    s_rx_arm |=> st.rx_state == HIA_RX_WAIT && !low_set[TOP_RX_EARLY])
    else $error("Receive delay fired early.");

  a_irq_masked: assert property ( // RULE18
    st.top_mask == '0 ##1 st.top_mask == '0 |-> !o_int)
    else $error("Interrupt raised with all mask bits clear.");

  a_wake_summary: assert property ( // RULE21
    i_ev.wake |=> st.pwr_event && !o_power_event_n && top_view[TOP_WAKE])
    else $error("Wake did not raise power event.");

  a_ou_reserved: assert property ( // RULE4
    (st.ou_ev & ~OU_VALID_BITS) == '0)
    else $error("Reserved overflow bits set.");

  a_wm_zero_off: assert property ( // RULE20
    st.wm_thr == '0 |-> !low_set[TOP_WMARK])
    else $error("Watermark fired while disabled.");

  a_qs_summary: assert property ( // RULE3
    (st.qs_ev & st.qs_mask) != '0 && st.top_mask[TOP_QS] |=> o_int)
    else $error("Queue status summary did not reach the pin.");

  sequence s_wm_enter;
    st.wm_thr != '0 && i_ev.free_blocks <= st.wm_thr && !st.below_wm;
  endsequence

  sequence s_wake_clear;
    i_wr && i_addr == OFS_POWER && i_wdata[PWR_EVENT] && !i_ev.wake;
  endsequence

  a_qs_fall_latch: assert property ( // RULE1
    i_ev.done_flag[0] ##1 !i_ev.done_flag[0] |=> st.qs_ev[QS_DONE_FALL])
    else $error("Queue 0 completion fall not latched.");

  a_qs_top_nibble: assert property ( // RULE1
    !i_ev.flag_a[HIA_NQ-1] ##1 i_ev.flag_a[HIA_NQ-1] |=> st.qs_ev[(HIA_NQ-1)*HIA_QW+QS_A_RISE])
    else $error("Top queue flag A rise not latched.");

  a_qs_read_clear: assert property ( // RULE2
    i_rd && i_addr == OFS_QS_EVENTS && qs_set == '0 |=> st.qs_ev == '0)
    else $error("Queue status events not cleared by read.");

  a_ou_read_clear: assert property ( // RULE2
    i_rd && i_addr == OFS_OU_EVENTS && ou_set == '0 |=> st.ou_ev == '0)
    else $error("Overflow events not cleared by read.");

  a_ou_overflow: assert property ( // RULE4
    i_ev.overflow[HIA_NQ-1] |=> st.ou_ev[(HIA_NQ-1)*HIA_QW+OU_OVERFLOW])
    else $error("Top queue overflow not latched.");

  a_ou_underrun: assert property ( // RULE4
    i_ev.underrun[0] |=> st.ou_ev[OU_UNDERRUN])
    else $error("Queue 0 underrun not latched.");

  a_ou_summary: assert property ( // RULE5
    (st.ou_ev & st.ou_mask) != '0 && st.top_mask[TOP_OU] |=> o_int)
    else $error("Overflow summary did not reach the pin.");

  a_tr_set: assert property ( // RULE6
    i_ev.tx_rollover != '0 |=> (st.tr_ev & $past(i_ev.tx_rollover)) == $past(i_ev.tx_rollover))
    else $error("Transmit rollover not latched.");

  a_rr_set: assert property ( // RULE7
    i_ev.rx_rollover != '0 |=> (st.rr_ev & $past(i_ev.rx_rollover)) == $past(i_ev.rx_rollover))
    else $error("Receive rollover not latched.");

  a_roll_summary: assert property ( // RULE8
    ((st.tr_ev & st.tr_mask) | (st.rr_ev & st.rr_mask)) != '0 && st.top_mask[TOP_ROLL] |=> o_int)
    else $error("Rollover summary did not reach the pin.");

  a_low_hold: assert property ( // RULE10
    !(i_rd && i_addr == OFS_TOP_STATUS) |=> (st.top_low & $past(st.top_low)) == $past(st.top_low))
    else $error("Top status bit lost without a read.");

  a_summary_no_clear: assert property ( // RULE10
    i_rd && i_addr == OFS_TOP_STATUS |=> st.qs_ev == ($past(st.qs_ev) | $past(qs_set)))
    else $error("Top status read cleared a source.");

  a_tx_bad_set: assert property ( // RULE11
    i_ev.tx_bad |=> st.top_low[TOP_TX_BAD])
    else $error("Transmit error bit not set.");

  a_rx_bad_set: assert property ( // RULE11
    i_ev.rx_bad |=> st.top_low[TOP_RX_BAD])
    else $error("Receive error bit not set.");

  a_rx_late_set: assert property ( // RULE12
    i_ev.rx_frame_done |=> st.top_low[TOP_RX_LATE])
    else $error("Late receive bit not set.");

  a_tx_early_set: assert property ( // RULE14
    i_ev.tx_start && i_ev.tx_notify_early |=> st.top_low[TOP_TX_EARLY])
    else $error("Early transmit bit not set.");

  a_tx_late_set: assert property ( // RULE14
    i_ev.tx_done && i_ev.tx_notify_late |=> st.top_low[TOP_TX_LATE])
    else $error("Late transmit bit not set.");

  a_tx_quiet: assert property ( // RULE14
    !st.top_low[TOP_TX_EARLY] && !(i_ev.tx_start && i_ev.tx_notify_early) |=> !st.top_low[TOP_TX_EARLY])
    else $error("Early transmit bit set without request.");

  a_wm_hit: assert property ( // RULE15
    s_wm_enter |=> st.top_low[TOP_WMARK])
    else $error("Watermark bit not set.");

  a_noblock_set: assert property ( // RULE16
    i_ev.no_block |=> st.top_low[TOP_NOBLOCK])
    else $error("No block bit not set.");

  a_pause_change: assert property ( // RULE17
    i_ev.pause_active != st.prev_pause |=> st.top_low[TOP_PAUSE])
    else $error("Pause change bit not set.");

  a_class_set: assert property ( // RULE17
    i_ev.class_irq |=> st.top_low[TOP_CLASS])
    else $error("Class bit not set.");

  a_pin_follows: assert property ( // RULE18
    (top_view & st.top_mask) != '0 |=> o_int)
    else $error("Unmasked status did not raise the pin.");

  a_pin_quiet: assert property ( // RULE22
    (top_view & st.top_mask) == '0 |=> !o_int)
    else $error("Pin raised with no unmasked status.");

  a_rx_delay_width: assert property ( // RULE19
    i_wr && i_addr == OFS_RX_DELAY |=> st.rx_delay_cfg == $past(i_wdata[RX_DELAY_W-1:0]))
    else $error("Receive delay not stored.");

  a_thr_write: assert property ( // RULE20
    i_wr && i_addr == OFS_WATERMARK |=> st.wm_thr == $past(i_wdata[WM_THR_LSB +: WM_THR_W]))
    else $error("Watermark threshold not stored.");

  a_wake_sticky: assert property ( // RULE21
    st.pwr_event && !(i_wr && i_addr == OFS_POWER) |=> st.pwr_event)
    else $error("Power event dropped without a write.");

  a_wake_clear: assert property ( // RULE21
    s_wake_clear |=> !st.pwr_event)
    else $error("Power event not cleared by write.");

endmodule // hia_aggregator
